//--- include/gie_pkg.sv
// grouped interrupt expander: shared constants, types and register map
package gie_pkg;

    // ------------------------------------------------------------------
    // structure sizes
    // ------------------------------------------------------------------
    localparam int unsigned GIE_NGRP  = 12;    // processor interrupt lines / groups
    localparam int unsigned GIE_NSRC  = 8;     // sources per group
    localparam int unsigned GIE_NEXT  = 3;     // irq one, irq two, non-maskable
    localparam int unsigned GIE_CNT_W = 16;    // stamp counter width

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] GIE_IDX_CTRL     = 16'h0CE0;  // expander_control
    localparam logic [15:0] GIE_IDX_ACK      = 16'h0CE1;  // group_acknowledge
    localparam logic [15:0] GIE_IDX_EN_BASE  = 16'h0CE2;  // group_source_enable, step 2
    localparam logic [15:0] GIE_IDX_FLG_BASE = 16'h0CE3;  // group_source_flag, step 2
    localparam logic [15:0] GIE_IDX_X1_CFG   = 16'h7070;  // ext_irq1_config
    localparam logic [15:0] GIE_IDX_X2_CFG   = 16'h7071;  // ext_irq2_config
    localparam logic [15:0] GIE_IDX_NMI_CFG  = 16'h7077;  // ext_nmi_config
    localparam logic [15:0] GIE_IDX_X1_CTR   = 16'h7078;  // ext_irq1_stamp_counter
    localparam logic [15:0] GIE_IDX_X2_CTR   = 16'h7079;  // ext_irq2_stamp_counter
    localparam logic [15:0] GIE_IDX_NMI_CTR  = 16'h707F;  // ext_nmi_stamp_counter
    localparam logic [15:0] GIE_IDX_GRP_STEP = 16'h0002;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned GIE_CTRL_FETCH_BIT = 0;   // vector_fetch_enable
    localparam int unsigned GIE_CFG_EN_BIT     = 0;   // input enable
    localparam int unsigned GIE_CFG_SEL_BIT    = 1;   // non-maskable routing select only
    localparam int unsigned GIE_CFG_POL_BIT    = 2;   // 1 rising, 0 falling
    localparam logic [2:0]  GIE_CFG_RST        = 3'h0;
    localparam logic [7:0]  GIE_EN_RST         = 8'h00;
    localparam logic [7:0]  GIE_FLG_RST        = 8'h00;
    localparam logic [15:0] GIE_CNT_RST        = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;     // one-cycle vector answer
        logic [3:0] group;     // 0 = first processor line
        logic [2:0] source;    // 0 = highest priority source
    } gie_vec_s;

endpackage : gie_pkg

//--- core/gie_expander.sv
// grouped interrupt expander with external interrupt configuration and stamps
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns

module gie_expander
    import gie_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [GIE_NGRP*GIE_NSRC-1:0] grouped_source_irq,
    output logic      [GIE_NGRP-1:0]        cpu_irq_line,
    input  wire logic                       fetch_req,
    input  wire logic [3:0]                 fetch_group,
    output gie_vec_s                        vec,
    output logic                            vector_fetch_enable,
    input  wire logic [GIE_NEXT-1:0]        ext_pin,
    output logic      [GIE_NEXT-1:0]        ext_irq_event
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // lowest set bit wins: source 0 has top priority
    function automatic logic [2:0] gie_first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = GIE_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : gie_first_set

    // index of a group register: base plus two per group
    function automatic logic [15:0] gie_grp_idx(input logic [15:0] base, input int g);
        return 16'(base + GIE_IDX_GRP_STEP * 16'(g));
    endfunction : gie_grp_idx

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]          en_q   [GIE_NGRP];
    logic [7:0]          en_d   [GIE_NGRP];
    logic [7:0]          flg_q  [GIE_NGRP];
    logic [7:0]          flg_d  [GIE_NGRP];
    logic [GIE_NGRP-1:0] blk_q, blk_d;
    logic [GIE_NGRP-1:0] irq_q, irq_d;
    logic [GIE_NGRP*GIE_NSRC-1:0] src_prev_q;
    logic                fetch_en_q, fetch_en_d;
    gie_vec_s            vec_q, vec_d;
    logic [2:0]          cfg_q  [GIE_NEXT];
    logic [2:0]          cfg_d  [GIE_NEXT];
    logic [15:0]         cnt_q  [GIE_NEXT];
    logic [15:0]         cnt_d  [GIE_NEXT];
    logic [GIE_NEXT-1:0] pin_prev_q, evt, evt_q;
    logic [31:0]         rdata_q, rdata_d;
    logic                ready_q, ready_d, err_q, err_d;
    logic [15:0]         idx;
    logic                aligned, wr_acc;
    logic [GIE_NGRP-1:0] ready_grp, issue, take;
    logic [2:0]          take_src [GIE_NGRP];

    assign idx     = paddr[17:2];
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0000);
    // a write lands only at the access edge that also sees pready, never on a refused address
    assign wr_acc  = psel && penable && pwrite && ready_q && aligned;

    // ------------------------------------------------------------------
    // apb slave: decode at the setup edge, answer in the access phase
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        ready_d = psel && !penable;
        if (psel && !penable) begin
            if (!aligned) begin
                err_d = 1'b1;
            end else if (idx == GIE_IDX_CTRL) begin
                rdata_d[GIE_CTRL_FETCH_BIT] = fetch_en_q;
            end else if (idx == GIE_IDX_ACK) begin
                rdata_d[GIE_NGRP-1:0] = blk_q;
            end else if (idx == GIE_IDX_X1_CFG || idx == GIE_IDX_X2_CFG) begin
                rdata_d[GIE_CFG_EN_BIT]  = cfg_q[idx == GIE_IDX_X2_CFG][GIE_CFG_EN_BIT];
                rdata_d[GIE_CFG_POL_BIT] = cfg_q[idx == GIE_IDX_X2_CFG][GIE_CFG_POL_BIT];
            end else if (idx == GIE_IDX_NMI_CFG) begin
                rdata_d[2:0] = cfg_q[2];
            end else if (idx == GIE_IDX_X1_CTR) begin
                rdata_d[15:0] = cnt_q[0];
            end else if (idx == GIE_IDX_X2_CTR) begin
                rdata_d[15:0] = cnt_q[1];
            end else if (idx == GIE_IDX_NMI_CTR) begin
                rdata_d[15:0] = cnt_q[2];
            end else begin
                err_d = 1'b1;
                for (int g = 0; g < GIE_NGRP; g++) begin
                    if (idx == gie_grp_idx(GIE_IDX_EN_BASE, g)) begin
                        rdata_d[7:0] = en_q[g];
                        err_d        = 1'b0;
                    end
                    if (idx == gie_grp_idx(GIE_IDX_FLG_BASE, g)) begin
                        rdata_d[7:0] = flg_q[g];
                        err_d        = 1'b0;
                    end
                end
            end
        end
    end

    // bus answer registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // per-group enable, flag, block and pulse
    // ------------------------------------------------------------------
    for (genvar g = 0; g < GIE_NGRP; g++) begin : g_grp
        logic [7:0] rise;
        logic [7:0] clr;
        assign rise         = grouped_source_irq[g*GIE_NSRC +: GIE_NSRC]
                            & ~src_prev_q[g*GIE_NSRC +: GIE_NSRC];
        assign ready_grp[g] = |(flg_q[g] & en_q[g]);
        // a fetch for this group takes the top pending enabled source
        assign take[g]      = fetch_req && fetch_en_q && (fetch_group == 4'(g))
                            && ready_grp[g];
        assign take_src[g]  = gie_first_set(flg_q[g] & en_q[g]);
        assign issue[g]     = fetch_en_q && ready_grp[g] && !blk_q[g];

        always_comb begin
            en_d[g]  = en_q[g];
            flg_d[g] = flg_q[g];
            clr      = 8'h00;
            if (wr_acc && idx == gie_grp_idx(GIE_IDX_EN_BASE, g)) begin
                en_d[g] = pwdata[7:0];
            end
            if (wr_acc && idx == gie_grp_idx(GIE_IDX_FLG_BASE, g)) begin
                clr = ~pwdata[7:0];
            end
            if (take[g]) begin
                clr[take_src[g]] = 1'b1;
            end
            // a new edge wins over any clear in the same cycle
            flg_d[g] = (flg_q[g] & ~clr) | rise;
        end

        always_comb begin
            blk_d[g] = blk_q[g];
            irq_d[g] = issue[g];
            if (wr_acc && idx == GIE_IDX_ACK && pwdata[g]) begin
                blk_d[g] = 1'b0;
            end
            if (issue[g]) begin
                blk_d[g] = 1'b1;
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                en_q[g]  <= GIE_EN_RST;
                flg_q[g] <= GIE_FLG_RST;
                blk_q[g] <= 1'b0;
                irq_q[g] <= 1'b0;
            end else begin
                en_q[g]  <= en_d[g];
                flg_q[g] <= flg_d[g];
                blk_q[g] <= blk_d[g];
                irq_q[g] <= irq_d[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // control bit and vector answer
    // ------------------------------------------------------------------
    always_comb begin
        fetch_en_d = fetch_en_q;
        vec_d      = '0;
        if (wr_acc && idx == GIE_IDX_CTRL) begin
            fetch_en_d = pwdata[GIE_CTRL_FETCH_BIT];
        end
        // bypassed: no vector comes from here and no flag is taken
        if (fetch_req && fetch_en_q && take[fetch_group]) begin
            vec_d.valid  = 1'b1;
            vec_d.group  = fetch_group;
            vec_d.source = take_src[fetch_group];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_en_q <= 1'b0;
            vec_q      <= '0;
            src_prev_q <= '0;
        end else begin
            fetch_en_q <= fetch_en_d;
            vec_q      <= vec_d;
            src_prev_q <= grouped_source_irq;
        end
    end

    // ------------------------------------------------------------------
    // external inputs: configuration, edge select, stamp counters
    // ------------------------------------------------------------------
    for (genvar x = 0; x < GIE_NEXT; x++) begin : g_ext
        localparam logic [15:0] CFG_IDX = (x == 0) ? GIE_IDX_X1_CFG
                                        : (x == 1) ? GIE_IDX_X2_CFG : GIE_IDX_NMI_CFG;
        // selected edge only, gated by the enable bit
        assign evt[x] = cfg_q[x][GIE_CFG_EN_BIT] && (cfg_q[x][GIE_CFG_POL_BIT]
                      ? (ext_pin[x] && !pin_prev_q[x])
                      : (!ext_pin[x] && pin_prev_q[x]));

        always_comb begin
            cfg_d[x] = cfg_q[x];
            cnt_d[x] = cnt_q[x];
            if (wr_acc && idx == CFG_IDX) begin
                cfg_d[x][GIE_CFG_EN_BIT]  = pwdata[GIE_CFG_EN_BIT];
                cfg_d[x][GIE_CFG_POL_BIT] = pwdata[GIE_CFG_POL_BIT];
                // routing select exists only for the non-maskable input
                cfg_d[x][GIE_CFG_SEL_BIT] = (x == 2) ? pwdata[GIE_CFG_SEL_BIT] : 1'b0;
            end
            if (evt[x]) begin
                cnt_d[x] = GIE_CNT_RST;
            end else if (cfg_q[x][GIE_CFG_EN_BIT]) begin
                cnt_d[x] = cnt_q[x] + 16'h0001;                        // wraps
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cfg_q[x]      <= GIE_CFG_RST;
                cnt_q[x]      <= GIE_CNT_RST;
                pin_prev_q[x] <= 1'b0;
                evt_q[x]      <= 1'b0;
            end else begin
                cfg_q[x]      <= cfg_d[x];
                cnt_q[x]      <= cnt_d[x];
                pin_prev_q[x] <= ext_pin[x];
                evt_q[x]      <= evt[x];
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign prdata              = rdata_q;
    assign pready              = ready_q;
    assign pslverr             = err_q;
    assign cpu_irq_line        = irq_q;
    assign vec                 = vec_q;
    assign vector_fetch_enable = fetch_en_q;
    assign ext_irq_event       = evt_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_pulse_blocks: assert property (
        cpu_irq_line[0] |-> blk_q[0] ##1 !cpu_irq_line[0])
        else $error("group pulse not followed by blocked state");
    chk_single_pulse: assert property (
        (cpu_irq_line[1] && !(wr_acc && idx == GIE_IDX_ACK && pwdata[1]))
        |=> !cpu_irq_line[1])
        else $error("second pulse without acknowledge");
    chk_pulse_cause: assert property (
        cpu_irq_line[2] |-> $past(ready_grp[2] && !blk_q[2] && fetch_en_q))
        else $error("pulse without enabled pending source");
    chk_ack_zero: assert property (
        (wr_acc && idx == GIE_IDX_ACK && !pwdata[3] && blk_q[3]) |=> blk_q[3])
        else $error("zero write changed acknowledge state");
    chk_ack_read: assert property (
        (psel && !penable && aligned && idx == GIE_IDX_ACK)
        |=> prdata[15:12] == 4'h0 && prdata[11:0] == $past(blk_q))
        else $error("acknowledge read wrong");
    chk_flag_set: assert property (
        (grouped_source_irq[0] && !src_prev_q[0]) |=> flg_q[0][0])
        else $error("flag missed a source edge");
    chk_fetch_clear: assert property (
        (take[4] && take_src[4] == 3'h4 && !grouped_source_irq[36]) |=> !flg_q[4][4])
        else $error("fetched flag not cleared");
    chk_bypass_vec: assert property (
        !vector_fetch_enable |=> !vec.valid ##1 1'b1)
        else $error("vector supplied while bypassed");
    chk_stamp_clear: assert property (
        evt[0] |=> cnt_q[0] == 16'h0000 ##1 (cnt_q[0] == 16'h0001 || evt_q[0]
                   || !cfg_q[0][GIE_CFG_EN_BIT]))
        else $error("stamp counter not cleared on edge");
    chk_stamp_stop: assert property (
        !cfg_q[1][GIE_CFG_EN_BIT] |=> $stable(cnt_q[1]))
        else $error("stamp counter ran while disabled");
    chk_flag_write: assert property (
        (wr_acc && idx == gie_grp_idx(GIE_IDX_FLG_BASE, 5) && !pwdata[6] && !take[5]
         && !(grouped_source_irq[46] && !src_prev_q[46])) |=> !flg_q[5][6])
        else $error("zero write did not clear flag");

    cov_pulse:   cover property (cpu_irq_line[0] ##[1:20] (wr_acc && idx == GIE_IDX_ACK));
    cov_fetch:   cover property (vec.valid);
    cov_ext_evt: cover property (ext_irq_event[2]);
    cov_wrap:    cover property (cnt_q[0] == 16'hFFFF ##1 cnt_q[0] == 16'h0000);

endmodule : gie_expander

//--- dv/gie_core_model.sv
// processor core model: takes group pulses and fetches their vectors
`timescale 1ns/1ns
module gie_core_model
    import gie_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [GIE_NGRP-1:0] cpu_irq_line,
    input  wire gie_vec_s            vec,
    input  wire logic [3:0]          slow_cycles,
    output logic                     fetch_req,
    output logic      [3:0]          fetch_group,
    output int                       pulse_count,
    output gie_vec_s                 last_vec
);
    logic [GIE_NGRP-1:0] pend_q;
    logic [3:0]          wait_q;
    int                  idx;

    // -----------------------------------------------------------------
    // queue pulses, fetch the lowest queued group, then wait a set number of cycles
    // -----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            wait_q <= 4'h0;
            fetch_req <= 1'b0;
            fetch_group <= 4'h0;
            pulse_count <= 0;
            last_vec <= '0;
        end else begin
            idx = -1;
            for (int i = GIE_NGRP - 1; i >= 0; i--) begin
                if (pend_q[i]) idx = i;
            end
            fetch_req <= 1'b0;
            fetch_group <= ~fetch_group;  // idle bus shows a changing pattern
            pend_q <= pend_q | cpu_irq_line;
            pulse_count <= pulse_count + $countones(cpu_irq_line);
            if (vec.valid === 1'b1) last_vec <= vec;
            if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
            else if (idx >= 0 && !fetch_req) begin
                fetch_req <= 1'b1;
                fetch_group <= 4'(idx);
                pend_q <= (pend_q | cpu_irq_line) & ~(12'h001 << idx);
                wait_q <= slow_cycles;
            end
        end
    end
endmodule : gie_core_model

//--- dv/tb.sv
// testbench for the grouped interrupt expander
`timescale 1ns/1ns
module tb
    import gie_pkg::*;
();
    logic                          core_clk = 1'b0;
    logic                          rst_n, psel, penable, pwrite, pready, pslverr, fetch_req, vfe, e;
    logic [31:0]                   paddr, pwdata, prdata, d1, d2;
    logic [GIE_NGRP*GIE_NSRC-1:0]  src;
    logic [GIE_NGRP-1:0]           irq;
    logic [3:0]                    fetch_group, slow;
    logic [2:0]                    ext_pin, ext_ev;
    gie_vec_s                      vec, last_vec;
    int                            failures = 0, cmp_count = 0, pulses, s, t;
    int                            ev_cnt[3] = '{0, 0, 0};

    gie_expander dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .grouped_source_irq(src), .cpu_irq_line(irq),
        .fetch_req(fetch_req), .fetch_group(fetch_group), .vec(vec),
        .vector_fetch_enable(vfe), .ext_pin(ext_pin), .ext_irq_event(ext_ev));
    gie_core_model core_u (.core_clk(core_clk), .rst_n(rst_n), .cpu_irq_line(irq), .vec(vec),
        .slow_cycles(slow), .fetch_req(fetch_req), .fetch_group(fetch_group),
        .pulse_count(pulses), .last_vec(last_vec));

    // -----------------------------------------------------------------
    // clock, event counting, watchdog
    // -----------------------------------------------------------------
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) if (ext_ev[i] === 1'b1) ev_cnt[i]++;
    end
    initial begin
        #80000;
        failures++;
        end_of_test();
    end

    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one APB transfer; request stays up so a setup may follow at once
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // wait for the access edge; a hang is ended by the watchdog
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask : apb
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] r;
        logic        x;
        apb(1'b1, idx, wd, r, x);
    endtask : wr
    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        x;
        apb(1'b0, idx, 32'h0, r, x);
        check(r, exp);
    endtask : rd_chk
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle
    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, src, ext_pin, slow} = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check({31'h0, vfe}, 32'h0);
        rd_chk(GIE_IDX_ACK, 32'h0);
        rd_chk(GIE_IDX_X1_CFG, 32'h0);
        rd_chk(GIE_IDX_NMI_CTR, 32'h0);
        apb(1'b0, 16'h7072, 32'h0, d1, e);
        check({31'h0, e}, 32'h1);
        wr(GIE_IDX_X1_CFG, 32'hFFFF);
        rd_chk(GIE_IDX_X1_CFG, 32'h5);
        wr(GIE_IDX_NMI_CFG, 32'hFFFA);
        rd_chk(GIE_IDX_NMI_CFG, 32'h2);
        // every group: one enabled and one disabled source raised while bypassed
        for (int g = 0; g < GIE_NGRP; g++) begin
            s = g % 8;
            t = (g + 1) % 8;
            src[g*8+s] <= 1'b1;
            src[g*8+t] <= 1'b1;
            wr(GIE_IDX_EN_BASE + 16'(2*g), 32'hFF00 | (32'h1 << s));
            rd_chk(GIE_IDX_EN_BASE + 16'(2*g), 32'h1 << s);
            rd_chk(GIE_IDX_FLG_BASE + 16'(2*g), (32'h1 << s) | (32'h1 << t));
        end
        src <= '0;
        check(pulses, 0);
        wr(GIE_IDX_CTRL, 32'h1);
        idle(40);
        check(pulses, 12);
        check({31'h0, vfe}, 32'h1);
        check({24'h0, last_vec}, 32'hDB);
        rd_chk(GIE_IDX_ACK, 32'hFFF);
        for (int g = 0; g < GIE_NGRP; g++) begin
            rd_chk(GIE_IDX_FLG_BASE + 16'(2*g), 32'h1 << ((g + 1) % 8));
        end
        // group 2 blocked, zero write, acknowledge, slow fetch
        slow <= 4'h5;
        src[18] <= 1'b1;
        idle(10);
        check(pulses, 12);
        wr(GIE_IDX_ACK, 32'h0);
        rd_chk(GIE_IDX_ACK, 32'hFFF);
        wr(GIE_IDX_ACK, 32'h4);
        idle(20);
        check(pulses, 13);
        check({24'h0, last_vec}, 32'h92);
        rd_chk(GIE_IDX_ACK, 32'hFFF);
        wr(GIE_IDX_ACK, 32'h4);
        idle(10);
        check(pulses, 13);
        rd_chk(GIE_IDX_ACK, 32'hFFB);
        wr(GIE_IDX_EN_BASE + 16'h4, 32'h8);
        idle(20);
        check(pulses, 14);
        check({24'h0, last_vec}, 32'h93);
        rd_chk(GIE_IDX_FLG_BASE + 16'h4, 32'h0);
        wr(GIE_IDX_FLG_BASE + 16'hA, 32'hFFBF);
        rd_chk(GIE_IDX_FLG_BASE + 16'hA, 32'h0);
        // external inputs: counting, edges, polarity, disable
        apb(1'b0, GIE_IDX_X1_CTR, 32'h0, d1, e);
        apb(1'b0, GIE_IDX_X1_CTR, 32'h0, d2, e);
        check(d2 - d1, 32'h2);
        ext_pin[0] <= 1'b1;
        idle(3);
        check(ev_cnt[0], 1);
        apb(1'b0, GIE_IDX_X1_CTR, 32'h0, d1, e);
        check({31'h0, d1 < 32'h10}, 32'h1);
        ext_pin[0] <= 1'b0;
        wr(GIE_IDX_X2_CFG, 32'h1);
        ext_pin[1] <= 1'b1;
        idle(3);
        check(ev_cnt[0] + ev_cnt[1], 1);
        ext_pin[1] <= 1'b0;
        ext_pin[2] <= 1'b1;
        idle(3);
        check(ev_cnt[1], 1);
        ext_pin[2] <= 1'b0;
        idle(3);
        check(ev_cnt[2], 0);
        rd_chk(GIE_IDX_NMI_CTR, 32'h0);
        wr(GIE_IDX_X1_CFG, 32'h0);
        apb(1'b0, GIE_IDX_X1_CTR, 32'h0, d1, e);
        apb(1'b0, GIE_IDX_X1_CTR, 32'h0, d2, e);
        check(d2, d1);
        idle(2);
        end_of_test();
    end
endmodule : tb
